/* File: dsn_dmem.sv */
`timescale 1ns/1ps
module dsn_dmem
  import dsn_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [11:0] mem_raddr,
  input  wire logic        mem_re,
  input  wire dsn_mem_wr_s mem_wr,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] junk = 8'h00;

  // The read returns while the strobe stands, so the core can take the
  // operand at the end of Q2. Outside the read slot the bus flips every
  // clock, so a late sample of the operand cannot match by luck.
  always @(posedge core_clk)
  begin
    if (mem_wr.we)
      mem[mem_wr.addr] <= mem_wr.wdata;
    junk <= ~junk;
  end

  assign mem_rdata = mem_re ? mem[mem_raddr] : junk;
endmodule

/* File: dsn_exec.sv */
`timescale 1ns/1ps
// Functional notes
// - Opcode 010011 with d, a and 8-bit address decrements the register.
// - With d clear the result goes to the accumulator, else to the register.
// - A nonzero result discards the prefetched next word as a no-op cycle.
// - One cycle without skip, two with skip, three over a two-word follower.
// - Each skip cycle performs nothing in any of its four quarter phases.
// - With a set the address is bank select register joined with the byte.
// - With a clear, extended set on and address up to 5Fh, indexed mode.
// - Otherwise a clear addresses the access bank, ignoring the bank select.
module dsn_exec
  import dsn_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] instr,
  input  wire logic        instr_valid,
  input  wire logic [15:0] next_word,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  mem_rdata,
  output logic [11:0]      mem_raddr,
  output logic             mem_re,
  output dsn_mem_wr_s      mem_wr,
  output logic [7:0]       wreg,
  output logic             busy,
  output logic             skip_active
);

  // ----------------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------------
  logic [1:0] qph;
  logic       cyc_end;

  dsn_qphase u_qphase
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .qph      (qph),
    .cyc_end  (cyc_end)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  dsn_state_e  state;
  dsn_state_e  next_state;
  logic [15:0] ir;
  logic [7:0]  operand;
  logic [7:0]  result;

  wire         hit      = instr_valid &&
                          instr[DSN_OP_MSB:DSN_OP_LSB] == DSN_OPCODE;
  wire         dest_f   = ir[DSN_DEST_BIT];
  wire         banked   = ir[DSN_BANK_BIT];
  wire [7:0]   faddr    = ir[7:0];
  wire         indexed  = !banked && ext_set_en &&
                          faddr <= DSN_INDEX_LIMIT;
  // Indexed mode adds the literal to a base from the indirect pointer.
  wire [11:0]  ea_index = index_base + {4'h0, faddr};
  wire [11:0]  ea_bank  = {bank_select_register, faddr};
  wire [11:0]  ea_acc   = {DSN_ACCESS_BANK, faddr};
  wire [11:0]  ea       = banked ? ea_bank :
                          (indexed ? ea_index : ea_acc);
  wire [7:0]   dec_val  = operand - 8'h01;
  wire         nonzero  = (result != 8'h00);
  // Two-word followers are recognised by their leading opcode nibble.
  wire         two_word = (next_word[15:12] == DSN_TWO_WORD_HI);
  wire         in_exec  = (state == DSN_EXEC);

  // ----------------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      DSN_IDLE:
        if (cyc_end && hit)
          next_state = DSN_EXEC;
      DSN_EXEC:
        if (cyc_end)
          next_state = nonzero ? DSN_SKIP : DSN_IDLE;
      DSN_SKIP:
        if (cyc_end)
          next_state = two_word ? DSN_SKIP2 : DSN_IDLE;
      DSN_SKIP2:
        if (cyc_end)
          next_state = DSN_IDLE;
      default:
        next_state = DSN_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= DSN_IDLE;
      ir    <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (state == DSN_IDLE && cyc_end && hit)
        ir <= instr;
    end
  end

  // ----------------------------------------------------------------------
  // Datapath per quarter phase
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_raddr   <= 12'h000;
      mem_re      <= 1'b0;
      operand     <= 8'h00;
      result      <= 8'h00;
      mem_wr      <= '0;
      wreg        <= DSN_ACC_RESET;
      busy        <= 1'b0;
      skip_active <= 1'b0;
    end
    else
    begin
      busy        <= (next_state != DSN_IDLE);
      skip_active <= (next_state == DSN_SKIP) ||
                     (next_state == DSN_SKIP2);
      mem_re      <= in_exec && qph == 2'h0;
      mem_wr.we   <= 1'b0;
      if (in_exec && qph == 2'h0)
        mem_raddr <= ea;
      if (in_exec && qph == 2'h1)
        operand <= mem_rdata;
      if (in_exec && qph == 2'h2)
      begin
        // Registered on the Q3 edge so the write stands during Q4 and
        // never spills into the first phase of a following skip cycle.
        result <= dec_val;
        if (dest_f)
        begin
          mem_wr.we    <= 1'b1;
          mem_wr.addr  <= mem_raddr;
          mem_wr.wdata <= dec_val;
        end
        else
          wreg <= dec_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_skip_idle;
    @(posedge core_clk) disable iff (!nrst)
      (state == DSN_SKIP) |-> !mem_wr.we && !mem_re;
  endproperty
  a_skip_idle: assert property (p_skip_idle)
    else $error("activity during skip cycle");

  property p_skip_on_nz;
    @(posedge core_clk) disable iff (!nrst)
      (in_exec && cyc_end && nonzero) |=> (state == DSN_SKIP);
  endproperty
  a_skip_on_nz: assert property (p_skip_on_nz)
    else $error("nonzero result did not skip");

  property p_noskip_zero;
    @(posedge core_clk) disable iff (!nrst)
      (in_exec && cyc_end && !nonzero) |=> (state == DSN_IDLE);
  endproperty
  a_noskip_zero: assert property (p_noskip_zero)
    else $error("zero result did not finish");

  property p_dec;
    @(posedge core_clk) disable iff (!nrst)
      (in_exec && qph == 2'h2) |=> (result == $past(operand) - 8'h01);
  endproperty
  a_dec: assert property (p_dec)
    else $error("decrement wrong");

  property p_wdest;
    @(posedge core_clk) disable iff (!nrst)
      (in_exec && qph == 2'h2 && !dest_f) |=> !mem_wr.we && wreg == result;
  endproperty
  a_wdest: assert property (p_wdest)
    else $error("accumulator destination wrong");

  property p_bank;
    @(posedge core_clk) disable iff (!nrst)
      (in_exec && qph == 2'h0 && banked) |=>
        mem_raddr == {$past(bank_select_register), $past(faddr)};
  endproperty
  a_bank: assert property (p_bank)
    else $error("banked address wrong");

  property p_access;
    @(posedge core_clk) disable iff (!nrst)
      (in_exec && qph == 2'h0 && !banked && !indexed) |=>
        mem_raddr[11:8] == DSN_ACCESS_BANK;
  endproperty
  a_access: assert property (p_access)
    else $error("access bank address wrong");

  property p_phase_read;
    @(posedge core_clk) disable iff (!nrst)
      mem_re |-> $past(qph) == 2'h0 && qph == 2'h1;
  endproperty
  a_phase_read: assert property (p_phase_read)
    else $error("read strobe outside second phase");

  property p_skip2;
    @(posedge core_clk) disable iff (!nrst)
      (state == DSN_SKIP && cyc_end && two_word) |=>
        (state == DSN_SKIP2) [*4] ##1 (state == DSN_IDLE);
  endproperty
  a_skip2: assert property (p_skip2)
    else $error("two-word skip length wrong");

  property p_index;
    @(posedge core_clk) disable iff (!nrst)
      (in_exec && qph == 2'h0 && indexed) |=>
        mem_raddr == $past(ea_index);
  endproperty
  a_index: assert property (p_index)
    else $error("indexed address wrong");

endmodule

/* File: dsn_pkg.sv */
package dsn_pkg;

  // ----------------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------------
  localparam logic [5:0] DSN_OPCODE       = 6'h13;
  localparam int         DSN_OP_MSB       = 15;
  localparam int         DSN_OP_LSB       = 10;
  localparam int         DSN_DEST_BIT     = 9;
  localparam int         DSN_BANK_BIT     = 8;
  localparam logic [7:0] DSN_INDEX_LIMIT  = 8'h5F;
  localparam logic [3:0] DSN_TWO_WORD_HI  = 4'hE;
  localparam logic [1:0] DSN_QPH_RESET    = 2'h0;
  localparam logic [7:0] DSN_ACC_RESET    = 8'h00;
  localparam logic [3:0] DSN_ACCESS_BANK  = 4'h0;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dsn_mem_wr_s;

  typedef enum logic [3:0] {
    DSN_EXEC = 4'b0001,
    DSN_SKIP = 4'b0010,
    DSN_SKIP2 = 4'b0100,
    DSN_IDLE = 4'b1000
  } dsn_state_e;

endpackage

/* File: dsn_qphase.sv */
`timescale 1ns/1ps
module dsn_qphase
  import dsn_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  output logic [1:0]      qph,
  output logic            cyc_end
);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      qph <= DSN_QPH_RESET;
    end
    else
    begin
      qph <= qph + 2'h1;
    end
  end

  assign cyc_end = (qph == 2'h3);

endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb
  import dsn_pkg::*;
;
  typedef struct packed {
    logic [7:0]  res;
    logic        d;
    logic [11:0] addr;
    logic [3:0]  nskip;
    logic [7:0]  w;
  } dsn_exp_s;

  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        instr_valid = 1'b0;
  logic [15:0] next_word = 16'h0000;
  logic [3:0]  bank_select_register = 4'h0;
  logic        ext_set_en = 1'b0;
  logic [11:0] index_base = 12'h000;
  logic [7:0]  mem_rdata;
  logic [11:0] mem_raddr;
  logic        mem_re;
  dsn_mem_wr_s mem_wr;
  logic [7:0]  wreg;
  logic        busy;
  logic        skip_active;
  int          failures = 0;
  int          num_checks = 0;
  int          bcnt, scnt, qops, wcnt;
  logic [19:0] wlast;
  logic [11:0] rlast;
  logic [7:0]  wreg_exp = DSN_ACC_RESET;
  logic        pbusy = 1'b0;
  dsn_exp_s    exp_q[$];
  dsn_exp_s    e;

  always #2.5 core_clk = ~core_clk;

  dsn_exec i_dsn_exec (.core_clk(core_clk), .nrst(nrst), .instr(instr),
    .instr_valid(instr_valid), .next_word(next_word),
    .bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
    .index_base(index_base), .mem_rdata(mem_rdata), .mem_raddr(mem_raddr),
    .mem_re(mem_re), .mem_wr(mem_wr), .wreg(wreg), .busy(busy),
    .skip_active(skip_active));

  dsn_dmem i_dsn_dmem (.core_clk(core_clk), .mem_raddr(mem_raddr),
    .mem_re(mem_re), .mem_wr(mem_wr), .mem_rdata(mem_rdata));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    chk(exp_q.size(), 0);
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Results are judged when busy drops, against the oldest note.
  always @(posedge core_clk)
  begin
    if (busy)
      bcnt++;
    if (skip_active)
      scnt++;
    if (skip_active && (mem_re || mem_wr.we))
      qops++;
    if (mem_re)
      rlast = mem_raddr;
    if (mem_wr.we)
    begin
      wcnt++;
      wlast = {mem_wr.addr, mem_wr.wdata};
    end
    if (pbusy && !busy && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk(bcnt, 4 + e.nskip);
      chk(scnt, e.nskip);
      chk(qops, 0);
      chk(rlast, e.addr);
      chk(wcnt, e.d);
      chk(wreg, e.w);
      if (e.d)
        chk(wlast, {e.addr, e.res});
    end
    pbusy = busy;
  end

  task automatic run(input logic d, a, ext, tw, input logic [7:0] f, op);
    logic [3:0]  b;
    logic [11:0] ib;
    dsn_exp_s    x;
    int          n;
    b = 4'($urandom);
    ib = 12'($urandom);
    x.d = d;
    x.addr = a ? {b, f} : (ext && f <= DSN_INDEX_LIMIT) ?
      ib + {4'h0, f} : {DSN_ACCESS_BANK, f};
    x.res = op - 8'h01;
    x.nskip = (x.res == 8'h00) ? 4'h0 : (tw ? 4'h8 : 4'h4);
    wreg_exp = d ? wreg_exp : x.res;
    x.w = wreg_exp;
    i_dsn_dmem.mem[x.addr] = op;
    exp_q.push_back(x);
    @(posedge core_clk);
    bcnt = 0;
    scnt = 0;
    qops = 0;
    wcnt = 0;
    instr <= {DSN_OPCODE, d, a, f};
    instr_valid <= 1'b1;
    next_word <= {tw ? DSN_TWO_WORD_HI : 4'h1, 12'($urandom)};
    ext_set_en <= ext;
    bank_select_register <= b;
    index_base <= ib;
    for (n = 0; n < 8 && busy !== 1'b1; n++)
      @(posedge core_clk);
    instr_valid <= 1'b0;
    for (n = 0; n < 24 && busy !== 1'b0; n++)
      @(posedge core_clk);
    @(posedge core_clk);
  endtask

  initial
  begin
    int n;
    void'($urandom(32'h3304));
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 40; i++)
      run(i[0], i[1], i[2], i[3] ^ i[1],
        i < 16 ? (i[3] ? 8'h5F : 8'h60) : 8'($urandom),
        i % 3 == 0 ? 8'h01 : i % 3 == 1 ? 8'h00 : 8'($urandom));
    $display("decrement table done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      instr <= k ? {DSN_OPCODE, 10'h3FF} : 16'h4BFF;
      instr_valid <= ~k[0];
      n = 0;
      repeat (8)
      begin
        @(posedge core_clk);
        if (busy !== 1'b0)
          n++;
      end
      chk(n, 0);
    end
    $display("refused words done");
    final_report();
  end

  initial
  begin
    #100000;
    failures++;
    final_report();
  end
endmodule
